// ### verilog/fpc_ctrl.sv
// Summary of operation
// - Protecting every sector before unprotect is left to the caller
// - Drive elevated level on output-enable, address nine
// - Hold chip-enable low, address six high
// - Unprotected sector reads 00h after identification command
// - Write only with chip, write low, output high
`include "fpc_cfg.svh"
`default_nettype none
module fpc_ctrl
   import fpc_pkg::*;
#(
   parameter int unsigned WPP2_CYC = `FPC_WPP2_CYC
) (
   input wire logic clk, // 20 MHz clock
   input wire logic reset, // Synchronous, active high
   input wire logic unprot_start, // Pulse: run whole-chip unprotect
   input wire logic check_start, // Pulse: read protect status of a sector
   input wire logic [4:0] check_sector, // Sector index to check
   output logic busy, // Sequence in progress
   output logic done, // Pulse: sequence finished
   output logic check_protected, // Last checked sector was protected
   output logic check_valid, // Last check read 00h or bit zero set cleanly
   output logic [17:0] flash_addr, // Address pins
   output logic [7:0] data_out, // Data pins, output value
   output logic data_oe, // Data pins driven by this module
   input wire logic [7:0] data_in, // Data pins, sampled value
   output logic chip_en_n, // Chip enable, active low
   output logic write_en_n, // Write enable, active low
   output logic out_en_n, // Output enable, active low
   output logic out_en_elev, // Elevated level request on output-enable
   output logic addr9_elev // Elevated level request on address nine
);
   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   fpc_state_e state_ff;
   logic [23:0] cnt_ff;
   logic [1:0] cmd_idx_ff;
   logic mode_unprot_ff;
   logic [4:0] sector_ff;
   logic [23:0] wait_len;
   logic [17:0] cmd_addr;
   fpc_byte_t cmd_data;
   always_comb begin
      cmd_addr = `FPC_UNLOCK_A1;
      cmd_data = `FPC_UNLOCK_D1;
      unique case (cmd_idx_ff)
         2'h0: begin
            cmd_addr = `FPC_UNLOCK_A1;
            cmd_data = `FPC_UNLOCK_D1;
         end
         2'h1: begin
            cmd_addr = `FPC_UNLOCK_A2;
            cmd_data = `FPC_UNLOCK_D2;
         end
         2'h2: begin
            cmd_addr = `FPC_UNLOCK_A1;
            cmd_data = `FPC_ID_CMD;
         end
         2'h3: begin
            cmd_addr = `FPC_UNLOCK_A1;
            cmd_data = `FPC_RESET_CMD;
         end
      endcase
   end
   always_comb begin
      wait_len = 24'(`FPC_WEP_CYC);
      if (state_ff == FPC_SETUP || state_ff == FPC_RECOVER)
         wait_len = 24'(`FPC_VLHT_CYC);
      else if (state_ff == FPC_WE_LOW)
         // One extra cycle lets write-enable rise while the levels still stand
         wait_len = 24'(WPP2_CYC) + 24'h1;
      else if (state_ff == FPC_RD_WAIT)
         wait_len = 24'(`FPC_RD_CYC);
   end
   wire cnt_done = (cnt_ff >= wait_len - 24'h1);
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= FPC_IDLE;
         cnt_ff <= 24'h0;
         cmd_idx_ff <= 2'h0;
         mode_unprot_ff <= 1'b0;
         sector_ff <= 5'h0;
      end else begin
         cnt_ff <= cnt_ff + 24'h1;
         unique case (state_ff)
            FPC_IDLE: begin
               cnt_ff <= 24'h0;
               cmd_idx_ff <= 2'h0;
               // Protecting every sector first is left to the caller
               if (unprot_start) begin
                  mode_unprot_ff <= 1'b1;
                  state_ff <= FPC_SETUP;
               end else if (check_start) begin
                  mode_unprot_ff <= 1'b0;
                  sector_ff <= check_sector;
                  state_ff <= FPC_CMD_SET;
               end
            end
            // Elevated levels settle before the write pulse is allowed
            FPC_SETUP: if (cnt_done) begin
               cnt_ff <= 24'h0;
               state_ff <= FPC_WE_LOW;
            end
            FPC_WE_LOW: if (cnt_done) begin
               cnt_ff <= 24'h0;
               state_ff <= FPC_RECOVER;
            end
            // Drop elevated levels, then verify via identification read
            FPC_RECOVER: if (cnt_done) begin
               cnt_ff <= 24'h0;
               sector_ff <= 5'h0;
               state_ff <= FPC_CMD_SET;
            end
            FPC_CMD_SET: begin
               cnt_ff <= 24'h0;
               state_ff <= FPC_CMD_LOW;
            end
            FPC_CMD_LOW: if (cnt_done) begin
               cnt_ff <= 24'h0;
               state_ff <= FPC_CMD_HIGH;
            end
            FPC_CMD_HIGH: begin
               cnt_ff <= 24'h0;
               if (cmd_idx_ff == 2'h2 || cmd_idx_ff == 2'h3) begin
                  state_ff <= (cmd_idx_ff == 2'h2) ? FPC_RD_SET : FPC_DONE;
               end else begin
                  cmd_idx_ff <= cmd_idx_ff + 2'h1;
                  state_ff <= FPC_CMD_SET;
               end
            end
            FPC_RD_SET: begin
               cnt_ff <= 24'h0;
               state_ff <= FPC_RD_WAIT;
            end
            FPC_RD_WAIT: if (cnt_done) begin
               cnt_ff <= 24'h0;
               cmd_idx_ff <= 2'h3;
               state_ff <= FPC_CMD_SET;
            end
            FPC_DONE: state_ff <= FPC_IDLE;
            default: state_ff <= FPC_IDLE;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         flash_addr <= 18'h0;
         data_out <= 8'h0;
         data_oe <= 1'b0;
         chip_en_n <= 1'b1;
         write_en_n <= 1'b1;
         out_en_n <= 1'b1;
         out_en_elev <= 1'b0;
         addr9_elev <= 1'b0;
      end else begin
         out_en_elev <= 1'b0;
         addr9_elev <= 1'b0;
         write_en_n <= 1'b1;
         out_en_n <= 1'b1;
         chip_en_n <= 1'b1;
         data_oe <= 1'b0;
         unique case (state_ff)
            FPC_SETUP, FPC_WE_LOW: begin
               out_en_elev <= 1'b1;
               addr9_elev <= 1'b1;
               chip_en_n <= 1'b0;
               flash_addr <= 18'h0;
               flash_addr[`FPC_BIT_SIX] <= 1'b1;
               flash_addr[`FPC_BIT_NINE] <= 1'b1;
               // Low for the full pulse time, high again before the levels drop
               write_en_n <= !(state_ff == FPC_WE_LOW && !cnt_done);
            end
            FPC_CMD_SET, FPC_CMD_LOW: begin
               chip_en_n <= 1'b0;
               flash_addr <= cmd_addr;
               data_out <= cmd_data;
               data_oe <= 1'b1;
               write_en_n <= !(state_ff == FPC_CMD_SET ||
                               (state_ff == FPC_CMD_LOW && !cnt_done));
            end
            FPC_CMD_HIGH: begin
               chip_en_n <= 1'b0;
               data_oe <= 1'b1;
            end
            FPC_RD_SET, FPC_RD_WAIT: begin
               chip_en_n <= 1'b0;
               out_en_n <= 1'b0;
               flash_addr <= {sector_ff, 13'h0};
               flash_addr[`FPC_BIT_ONE] <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Status
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         busy <= 1'b0;
         done <= 1'b0;
         check_protected <= 1'b0;
         check_valid <= 1'b0;
      end else begin
         busy <= (state_ff != FPC_IDLE) && (state_ff != FPC_DONE);
         done <= (state_ff == FPC_DONE);
         // Sample on the last read cycle, giving access time to settle
         if (state_ff == FPC_RD_WAIT && cnt_done) begin
            check_protected <= data_in[0];
            check_valid <= (data_in[7:1] == 7'h0);
         end
      end
   end
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_write_inhibit: assert property (@(posedge clk) disable iff (reset)
      !write_en_n |-> !chip_en_n && out_en_n)
      else $error("write pulse without chip enable or with output enable");
   a_unprot_levels: assert property (@(posedge clk) disable iff (reset)
      (!write_en_n && out_en_elev) |-> addr9_elev && flash_addr[6] && !chip_en_n)
      else $error("unprotect pulse without full selection");
   a_elev_pair: assert property (@(posedge clk) disable iff (reset)
      out_en_elev == addr9_elev)
      else $error("elevated levels not applied together");
   a_we_framed: assert property (@(posedge clk) disable iff (reset)
      $fell(write_en_n) && out_en_elev |-> $past(out_en_elev))
      else $error("write pulse fell before elevated setup");
   a_elev_release: assert property (@(posedge clk) disable iff (reset)
      $rose(write_en_n) && $past(out_en_elev) |=> !out_en_elev)
      else $error("elevated levels held after unprotect pulse");
   a_cmd_order: assert property (@(posedge clk) disable iff (reset)
      $fell(write_en_n) && data_out == 8'h90 && !out_en_elev
         |-> $past(data_out, 3) != 8'h90)
      else $error("command cycle issued out of order");
   a_read_addr: assert property (@(posedge clk) disable iff (reset)
      !out_en_n |-> flash_addr[1] && write_en_n)
      else $error("status read without address one high");
   a_done_pulse: assert property (@(posedge clk) disable iff (reset)
      done |=> !done)
      else $error("done longer than one cycle");
   a_oe_idle: assert property (@(posedge clk) disable iff (reset)
      !busy && !done |-> !data_oe && chip_en_n)
      else $error("pins active while idle");
endmodule
`default_nettype wire

// ### pkg/fpc_cfg.svh
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
// Timing counts at 20 MHz (50 ns period)
`define FPC_CLK_NS 50
`define FPC_VLHT_NS 4000
`define FPC_VLHT_CYC ((`FPC_VLHT_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_WPP2_NS 12000000
`define FPC_WPP2_CYC ((`FPC_WPP2_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_WEP_NS 50
`define FPC_WEP_CYC ((`FPC_WEP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_RD_NS 150
`define FPC_RD_CYC ((`FPC_RD_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
// Command cycles for identification read
`define FPC_UNLOCK_A1 18'h00555
`define FPC_UNLOCK_D1 8'haa
`define FPC_UNLOCK_A2 18'h002aa
`define FPC_UNLOCK_D2 8'h55
`define FPC_ID_CMD 8'h90
`define FPC_RESET_CMD 8'hf0
// Address field positions
`define FPC_BIT_ONE 1
`define FPC_BIT_SIX 6
`define FPC_BIT_NINE 9
`define FPC_SECTOR_LSB 13
`endif

// ### pkg/fpc_pkg.sv
`default_nettype none
package fpc_pkg;
   typedef enum logic [3:0] {
      FPC_IDLE = 4'h0,
      FPC_SETUP = 4'h1,
      FPC_WE_LOW = 4'h3,
      FPC_RECOVER = 4'h2,
      FPC_CMD_SET = 4'h6,
      FPC_CMD_LOW = 4'h7,
      FPC_CMD_HIGH = 4'h5,
      FPC_RD_SET = 4'h4,
      FPC_RD_WAIT = 4'hc,
      FPC_DONE = 4'hd
   } fpc_state_e;
   typedef logic [7:0] fpc_byte_t;
endpackage
`default_nettype wire

// ### tb/fpc_flash_model.sv
`include "fpc_cfg.svh"
`default_nettype none
module fpc_flash_model (
   input wire logic [17:0] flash_addr, // Address pins
   input wire logic [7:0] data_out, // Data from controller
   input wire logic data_oe, // Controller drives data
   output logic [7:0] data_in, // Data pins as seen by controller
   input wire logic chip_en_n, // Chip enable, active low
   input wire logic write_en_n, // Write enable, active low
   input wire logic out_en_n, // Output enable, active low
   input wire logic out_en_elev, // Elevated level on output-enable
   input wire logic addr9_elev // Elevated level on address nine
);
   timeunit 1ns;
   timeprecision 1ns;
   parameter logic [7:0] ID_CODE = 8'h5a; // Arbitrary value
   logic [31:0] prot = 32'h00000000;
   logic id_mode = 1'b0;
   logic [1:0] step = 2'h0;
   logic unprot_on = 1'b0;
   logic [7:0] last = 8'h00;
   logic [7:0] rd_val;
   wire logic sel = !chip_en_n && !out_en_n && !out_en_elev && !data_oe;
   always @(negedge write_en_n) begin
      unprot_on <= out_en_elev && addr9_elev && !chip_en_n && flash_addr[6];
   end
   always @(posedge write_en_n) begin
      if (unprot_on) begin
         prot <= 32'h00000000;
      end else if (!chip_en_n && out_en_n && !out_en_elev) begin
         // Only a full unlock pair opens the command slot
         step <= 2'h0;
         if (step == 2'h0 && data_out == `FPC_UNLOCK_D1 && flash_addr == `FPC_UNLOCK_A1) begin
            step <= 2'h1;
         end
         if (step == 2'h1 && data_out == `FPC_UNLOCK_D2 && flash_addr == `FPC_UNLOCK_A2) begin
            step <= 2'h2;
         end
         if (step == 2'h2 && data_out == `FPC_ID_CMD) begin
            id_mode <= 1'b1;
         end
         if (data_out == `FPC_RESET_CMD) begin
            id_mode <= 1'b0;
         end
      end
   end
   always_comb begin
      if (id_mode) begin
         rd_val = flash_addr[1] ? {7'h00, prot[flash_addr[17:13]]} : ID_CODE;
      end else begin
         rd_val = 8'h3c;
      end
   end
   // Released bus shows the inverse of the last byte, never a stale match
   always @(rd_val or sel) if (sel) last = rd_val;
   assign data_in = sel ? rd_val : ~last;
endmodule
`default_nettype wire

// ### tb/fpc_ctrl_test.sv
`default_nettype none
module fpc_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned WPP = 10;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic unprot_start = 1'b0;
   logic check_start = 1'b0;
   logic [4:0] check_sector = 5'h00;
   logic busy, done, check_protected, check_valid, data_oe;
   logic chip_en_n, write_en_n, out_en_n, out_en_elev, addr9_elev;
   logic [17:0] flash_addr;
   logic [7:0] data_out, data_in;
   int mismatches = 0;
   int comparisons = 0;
   int low_cnt = 0;
   fpc_ctrl #(.WPP2_CYC(WPP)) DUT (.clk, .reset, .unprot_start, .check_start, .check_sector,
      .busy, .done, .check_protected, .check_valid, .flash_addr, .data_out, .data_oe,
      .data_in, .chip_en_n, .write_en_n, .out_en_n, .out_en_elev, .addr9_elev);
   fpc_flash_model mdl (.flash_addr, .data_out, .data_oe, .data_in, .chip_en_n,
      .write_en_n, .out_en_n, .out_en_elev, .addr9_elev);
   initial forever #25 clk = ~clk;
   // Cycles of the long write pulse under elevated levels
   always @(posedge clk) if (!write_en_n && addr9_elev) low_cnt <= low_cnt + 1;
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask
   task automatic run(input logic unp, input logic [4:0] sec, input logic hit);
      int n;
      n = 0;
      @(posedge clk);
      unprot_start <= unp;
      check_start <= !unp;
      check_sector <= sec;
      @(posedge clk);
      unprot_start <= hit;
      check_start <= 1'b0;
      @(posedge clk);
      unprot_start <= 1'b0;
      while (done !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      cmp(n < 2000, 1'b1, "done missing");
   endtask
   task automatic t_reset;
      cmp({busy, chip_en_n, write_en_n, out_en_elev, addr9_elev}, 5'h0c, "reset pins");
      cmp(mdl.id_mode, 1'b0, "power-up array read");
      $display("test reset done");
   endtask
   task automatic t_check;
      mdl.prot = 32'h80000020;
      run(1'b0, 5'h05, 1'b0);
      cmp({check_protected, check_valid}, 2'h3, "sector 5");
      run(1'b0, 5'h06, 1'b0);
      cmp({check_protected, check_valid}, 2'h1, "sector 6");
      run(1'b0, 5'h1f, 1'b0);
      cmp({check_protected, check_valid}, 2'h3, "sector 31");
      cmp(mdl.id_mode, 1'b0, "back to array read");
      $display("test check done");
   endtask
   task automatic t_refused;
      run(1'b0, 5'h06, 1'b1);
      repeat (100) @(posedge clk);
      cmp(mdl.prot, 32'h80000020, "start while busy");
      $display("test refused done");
   endtask
   task automatic t_unprot;
      // Every sector protected first, so a failed unprotect shows up
      mdl.prot = 32'hffffffff;
      run(1'b1, 5'h00, 1'b0);
      cmp(low_cnt, WPP, "pulse width");
      cmp(mdl.prot, 32'h00000000, "all sectors");
      cmp({check_protected, check_valid}, 2'h1, "verify 0");
      run(1'b0, 5'h05, 1'b0);
      cmp({check_protected, check_valid}, 2'h1, "after levels");
      $display("test unprotect done");
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      t_reset();
      t_check();
      t_refused();
      t_unprot();
      complete_run();
   end
endmodule
`default_nettype wire
